// [verilog/aalu_defines.svh]
// constants of the accumulator alu: widths, field positions, reset values
`ifndef AALU_DEFINES_SVH
`define AALU_DEFINES_SVH
`define AALU_WIDTH 16
`define AALU_ACC_COUNT 16
`define AALU_INDEX_RESET 4'h0
`define AALU_STEP_RESET 8'h00
`define AALU_ACC_RESET 16'h0000
`define AALU_STEP_DOWN_BIT 6
`define AALU_STEP_MODE_MSB 2
`define AALU_FLAG_EQUALS 0
`define AALU_FLAG_CARRY 1
`define AALU_FLAG_OVERFLOW 2
`define AALU_FLAG_SIGN 6
`define AALU_FLAG_ZERO 7
`endif

// [verilog/aalu_pkg.sv]
// types of the accumulator alu: operation codes
package aalu_pkg;
	typedef enum logic [5:0] {
		OP_NOP = 6'h00, OP_ADD = 6'h01, OP_ADDC = 6'h02, OP_SUB = 6'h03,
		OP_SUBB = 6'h04, OP_AND = 6'h05, OP_OR = 6'h06, OP_XOR = 6'h07,
		OP_CMP = 6'h08, OP_CPL = 6'h09, OP_NEG = 6'h0A, OP_ROL = 6'h0B,
		OP_RLC = 6'h0C, OP_ROR = 6'h0D, OP_RRC = 6'h0E, OP_ASL = 6'h0F,
		OP_ASL2 = 6'h10, OP_ASL4 = 6'h11, OP_ASR = 6'h12, OP_ASR2 = 6'h13,
		OP_ASR4 = 6'h14, OP_LSR = 6'h15, OP_XCHN = 6'h16, OP_XCH = 6'h17,
		OP_MOVE_TO_ACC = 6'h18, OP_MOVE_FROM_ACC = 6'h19,
		OP_MOVE_FROM_PTR = 6'h1A, OP_BIT_TO_C = 6'h1B, OP_C_TO_BIT = 6'h1C,
		OP_BIT_AND = 6'h1D, OP_BIT_OR = 6'h1E, OP_BIT_XOR = 6'h1F,
		OP_C_IMM = 6'h20, OP_C_CPL = 6'h21, OP_C_FROM_SRC = 6'h22,
		OP_JUMP_E = 6'h23, OP_JUMP_NE = 6'h24
	} aalu_op_type;
endpackage

// [verilog/aalu_core.sv]
// accumulator bank, alu, index stepping and status flags
// What this block does
// RULE1: four-bit index picks one of sixteen accumulators
// RULE2: step control codes mode and down direction
// RULE3: pointer-notation move never steps; acc destination illegal
// RULE4: stepping changes only the selected low index field
// RULE5: stepped field wraps, upper index bits kept
// RULE6: source ops use accumulator; accumulator source illegal
// RULE7: compare sets equals when source matches accumulator
// RULE8: inversion and negation as inverted plus one
// RULE9: plain rotates skip carry; through-carry rotates include
// RULE10: arithmetic shifts by one, two, four bits
// RULE11: logical right shift: bit0 to carry, zero in
// RULE12: nibble swap within bytes and byte swap
// RULE13: carry bit ops address accumulator bits 0-7
// RULE14: bit and/or/xor result goes to carry
// RULE15: carry bit operations never step the index
// RULE16: sign flag mirrors bit 15 of selected accumulator
// RULE17: zero flag shows selected accumulator all zero
// RULE18: flag register write can change equals flag
// RULE19: carry from arithmetic, shifts and carry rotates
// RULE20: carry set, cleared, complemented or loaded
// RULE21: add/subtract with carry use current carry
// RULE22: equals jumps accept immediate destination only
// RULE23: overflow when carry out differs from top carry
// RULE24: compare leaves accumulator and index unchanged
`timescale 1ns/1ps
`include "aalu_defines.svh"
module aalu_core #(
	parameter int WIDTH = `AALU_WIDTH,
	parameter int ACC_COUNT = `AALU_ACC_COUNT
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic op_valid,
	input wire aalu_pkg::aalu_op_type op_code,
	input wire logic [15:0] src_data,
	input wire logic src_is_acc,
	input wire logic dst_is_acc,
	input wire logic src_is_imm,
	input wire logic [2:0] bit_sel,
	input wire logic imm_bit,
	input wire logic index_wr,
	input wire logic [3:0] index_wdata,
	input wire logic step_ctrl_wr,
	input wire logic [7:0] step_ctrl_wdata,
	input wire logic flag_wr,
	input wire logic [7:0] flag_wdata,
	input wire logic acc_wr,
	input wire logic [3:0] acc_wr_sel,
	input wire logic [15:0] acc_wr_data,
	output logic [15:0] acc_out,
	output logic [15:0] move_data,
	output logic [3:0] accumulator_index,
	output logic [7:0] index_step_control,
	output logic [7:0] flag_register,
	output logic jump_taken,
	output logic op_illegal
);
	// refuse shapes the fixed datapath cannot serve
	if (WIDTH != 16 || ACC_COUNT != 16) begin : g_check
		$error("aalu_core supports only 16 accumulators of 16 bits");
	end

	typedef struct packed {
		logic [15:0][15:0] acc;
		logic [3:0] index;
		logic [7:0] step;
		logic carry;
		logic overflow;
		logic equals;
		logic [15:0] move;
		logic jump;
		logic illegal;
	} aalu_state_type;

	aalu_state_type state_reg;
	aalu_state_type state_next;

	// next index after one step, only the selected field moves
	function automatic logic [3:0] step_index(input logic [3:0] idx,
			input logic [7:0] ctrl);
		logic [3:0] mask;
		logic [3:0] moved;
		case (ctrl[`AALU_STEP_MODE_MSB:0])
			3'h1: mask = 4'h1;
			3'h2: mask = 4'h3;
			3'h3: mask = 4'h7;
			3'h4: mask = 4'hF;
			default: mask = 4'h0;
		endcase
		moved = ctrl[`AALU_STEP_DOWN_BIT] ? idx - 4'h1 : idx + 4'h1;
		return (idx & ~mask) | (moved & mask); // [RULE2] [RULE4] [RULE5]
	endfunction

	// operations after which the index may step
	function automatic logic steps_index(input aalu_pkg::aalu_op_type op);
		case (op)
			aalu_pkg::OP_ADD, aalu_pkg::OP_ADDC, aalu_pkg::OP_SUB,
			aalu_pkg::OP_SUBB, aalu_pkg::OP_AND, aalu_pkg::OP_OR,
			aalu_pkg::OP_XOR, aalu_pkg::OP_CPL, aalu_pkg::OP_NEG,
			aalu_pkg::OP_ROL, aalu_pkg::OP_RLC, aalu_pkg::OP_ROR,
			aalu_pkg::OP_RRC, aalu_pkg::OP_ASL, aalu_pkg::OP_ASL2,
			aalu_pkg::OP_ASL4, aalu_pkg::OP_ASR, aalu_pkg::OP_ASR2,
			aalu_pkg::OP_ASR4, aalu_pkg::OP_LSR, aalu_pkg::OP_XCHN,
			aalu_pkg::OP_XCH, aalu_pkg::OP_MOVE_TO_ACC,
			aalu_pkg::OP_MOVE_FROM_ACC: return 1'b1;
			default: return 1'b0; // [RULE3] [RULE15] [RULE24]
		endcase
	endfunction

	// operations that take an outside source against the accumulator
	function automatic logic uses_source(input aalu_pkg::aalu_op_type op);
		case (op)
			aalu_pkg::OP_ADD, aalu_pkg::OP_ADDC, aalu_pkg::OP_SUB,
			aalu_pkg::OP_SUBB, aalu_pkg::OP_AND, aalu_pkg::OP_OR,
			aalu_pkg::OP_XOR, aalu_pkg::OP_CMP: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	logic [15:0] acc_cur;
	logic refuse;

	// working accumulator and refusal of illegal operand forms
	assign acc_cur = state_reg.acc[state_reg.index]; // [RULE1]
	assign refuse = op_valid && (
		(uses_source(op_code) && src_is_acc) || // [RULE6]
		(op_code == aalu_pkg::OP_MOVE_FROM_PTR && dst_is_acc) || // [RULE3]
		((op_code == aalu_pkg::OP_JUMP_E ||
			op_code == aalu_pkg::OP_JUMP_NE) && !src_is_imm)); // [RULE22]

	// next state of the whole block
	always_comb begin
		logic [16:0] wide;
		logic [15:0] res;
		logic low_carry;
		logic wr_acc;
		state_next = state_reg;
		wide = 17'h00000;
		res = acc_cur;
		low_carry = 1'b0;
		wr_acc = 1'b0;
		state_next.jump = 1'b0;
		state_next.illegal = refuse;
		if (op_valid && !refuse) begin
			wr_acc = 1'b1;
			case (op_code)
				aalu_pkg::OP_ADD, aalu_pkg::OP_ADDC: begin
					low_carry = op_code == aalu_pkg::OP_ADDC && state_reg.carry;
					wide = {1'b0, acc_cur} + {1'b0, src_data} +
						{16'h0000, low_carry}; // [RULE21]
					res = wide[15:0];
					state_next.carry = wide[16]; // [RULE19]
					state_next.overflow = wide[16] ^
						(acc_cur[15] ^ src_data[15] ^ wide[15]); // [RULE23]
				end
				aalu_pkg::OP_SUB, aalu_pkg::OP_SUBB: begin
					low_carry = op_code == aalu_pkg::OP_SUBB && state_reg.carry;
					wide = {1'b0, acc_cur} - {1'b0, src_data} -
						{16'h0000, low_carry}; // [RULE21]
					res = wide[15:0];
					state_next.carry = wide[16]; // [RULE19]
					state_next.overflow = wide[16] ^
						(acc_cur[15] ^ src_data[15] ^ wide[15]); // [RULE23]
				end
				aalu_pkg::OP_AND: res = acc_cur & src_data; // [RULE6]
				aalu_pkg::OP_OR: res = acc_cur | src_data;
				aalu_pkg::OP_XOR: res = acc_cur ^ src_data;
				aalu_pkg::OP_CMP: begin
					wr_acc = 1'b0; // [RULE24]
					state_next.equals = src_data == acc_cur; // [RULE7]
				end
				aalu_pkg::OP_CPL: res = ~acc_cur; // [RULE8]
				aalu_pkg::OP_NEG: res = ~acc_cur + 16'h0001; // [RULE8]
				aalu_pkg::OP_ROL: res = {acc_cur[14:0], acc_cur[15]}; // [RULE9]
				aalu_pkg::OP_ROR: res = {acc_cur[0], acc_cur[15:1]};
				aalu_pkg::OP_RLC: begin
					res = {acc_cur[14:0], state_reg.carry}; // [RULE9]
					state_next.carry = acc_cur[15];
				end
				aalu_pkg::OP_RRC: begin
					res = {state_reg.carry, acc_cur[15:1]};
					state_next.carry = acc_cur[0]; // [RULE19]
				end
				aalu_pkg::OP_ASL: begin
					res = {acc_cur[14:0], 1'b0}; // [RULE10]
					state_next.carry = acc_cur[15];
				end
				aalu_pkg::OP_ASL2: begin
					res = {acc_cur[13:0], 2'h0};
					state_next.carry = acc_cur[14];
				end
				aalu_pkg::OP_ASL4: begin
					res = {acc_cur[11:0], 4'h0};
					state_next.carry = acc_cur[12];
				end
				aalu_pkg::OP_ASR: begin
					res = {acc_cur[15], acc_cur[15:1]}; // [RULE10]
					state_next.carry = acc_cur[0];
				end
				aalu_pkg::OP_ASR2: begin
					res = {{2{acc_cur[15]}}, acc_cur[15:2]};
					state_next.carry = acc_cur[1];
				end
				aalu_pkg::OP_ASR4: begin
					res = {{4{acc_cur[15]}}, acc_cur[15:4]};
					state_next.carry = acc_cur[3];
				end
				aalu_pkg::OP_LSR: begin
					res = {1'b0, acc_cur[15:1]}; // [RULE11]
					state_next.carry = acc_cur[0];
				end
				aalu_pkg::OP_XCHN: res = {acc_cur[11:8], acc_cur[15:12],
					acc_cur[3:0], acc_cur[7:4]}; // [RULE12]
				aalu_pkg::OP_XCH: res = {acc_cur[7:0], acc_cur[15:8]};
				aalu_pkg::OP_MOVE_TO_ACC: res = src_data;
				aalu_pkg::OP_MOVE_FROM_ACC, aalu_pkg::OP_MOVE_FROM_PTR: begin
					wr_acc = 1'b0;
					state_next.move = acc_cur;
				end
				aalu_pkg::OP_BIT_TO_C: begin
					wr_acc = 1'b0;
					state_next.carry = acc_cur[bit_sel]; // [RULE13]
				end
				aalu_pkg::OP_C_TO_BIT: res[bit_sel] = state_reg.carry;
				aalu_pkg::OP_BIT_AND, aalu_pkg::OP_BIT_OR,
				aalu_pkg::OP_BIT_XOR: begin
					wr_acc = 1'b0;
					case (op_code)
						aalu_pkg::OP_BIT_AND: state_next.carry =
							state_reg.carry & acc_cur[bit_sel]; // [RULE14]
						aalu_pkg::OP_BIT_OR: state_next.carry =
							state_reg.carry | acc_cur[bit_sel];
						default: state_next.carry =
							state_reg.carry ^ acc_cur[bit_sel];
					endcase
				end
				aalu_pkg::OP_C_IMM, aalu_pkg::OP_C_FROM_SRC: begin
					wr_acc = 1'b0;
					state_next.carry = imm_bit; // [RULE20]
				end
				aalu_pkg::OP_C_CPL: begin
					wr_acc = 1'b0;
					state_next.carry = ~state_reg.carry; // [RULE20]
				end
				aalu_pkg::OP_JUMP_E, aalu_pkg::OP_JUMP_NE: begin
					wr_acc = 1'b0;
					state_next.jump = (op_code == aalu_pkg::OP_JUMP_E) ==
						state_reg.equals; // [RULE22]
				end
				default: wr_acc = 1'b0;
			endcase
			if (wr_acc)
				state_next.acc[state_reg.index] = res;
			if (steps_index(op_code))
				state_next.index = step_index(state_reg.index,
					state_reg.step); // [RULE4]
		end
		// direct transfers from the register bus
		if (acc_wr)
			state_next.acc[acc_wr_sel] = acc_wr_data;
		if (index_wr)
			state_next.index = index_wdata;
		if (step_ctrl_wr)
			state_next.step = step_ctrl_wdata;
		if (flag_wr) begin
			state_next.equals = flag_wdata[`AALU_FLAG_EQUALS]; // [RULE18]
			state_next.carry = flag_wdata[`AALU_FLAG_CARRY];
			state_next.overflow = flag_wdata[`AALU_FLAG_OVERFLOW];
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= '0;
			state_reg.index <= `AALU_INDEX_RESET;
			state_reg.step <= `AALU_STEP_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs; sign and zero follow the selected accumulator live
	assign acc_out = acc_cur;
	assign move_data = state_reg.move;
	assign accumulator_index = state_reg.index;
	assign index_step_control = state_reg.step;
	assign jump_taken = state_reg.jump;
	assign op_illegal = state_reg.illegal;
	assign flag_register = {acc_cur == 16'h0000, acc_cur[15], // [RULE16] [RULE17]
		3'h0, state_reg.overflow, state_reg.carry, state_reg.equals};

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	logic plain_op;
	assign plain_op = op_valid && !refuse && !index_wr && !flag_wr && !acc_wr;

	sequence s_step_issue;
		plain_op && steps_index(op_code);
	endsequence
	chk_step_field: assert property (s_step_issue ##1 1'b1 |-> // [RULE5]
		accumulator_index == step_index($past(accumulator_index),
		$past(index_step_control)))
		else $error("index step wrong");
	chk_upper_kept: assert property (s_step_issue and // [RULE4]
		index_step_control[2:0] == 3'h1 |=>
		accumulator_index[3:1] == $past(accumulator_index[3:1]))
		else $error("upper index bits changed");
	chk_cmp_equal: assert property (plain_op && // [RULE7]
		op_code == aalu_pkg::OP_CMP |=>
		flag_register[0] == ($past(src_data) == $past(acc_out)))
		else $error("compare equals flag wrong");
	chk_cmp_keeps: assert property (plain_op && // [RULE24]
		op_code == aalu_pkg::OP_CMP |=>
		$stable(acc_out) && $stable(accumulator_index))
		else $error("compare changed accumulator");
	chk_sign_mirror: assert property (index_wr |=> // [RULE16]
		flag_register[6] == state_reg.acc[$past(index_wdata)][15])
		else $error("sign flag mismatch");
	chk_zero_mirror: assert property (index_wr |=> // [RULE17]
		flag_register[7] == (state_reg.acc[$past(index_wdata)] == 16'h0000))
		else $error("zero flag mismatch");
	chk_bit_nostep: assert property (plain_op && (op_code inside // [RULE15]
		{aalu_pkg::OP_BIT_AND, aalu_pkg::OP_BIT_OR, aalu_pkg::OP_BIT_XOR,
		aalu_pkg::OP_C_TO_BIT, aalu_pkg::OP_BIT_TO_C}) && !step_ctrl_wr
		|=> $stable(accumulator_index))
		else $error("bit operation stepped index");
	chk_sr_carry: assert property (plain_op && // [RULE11]
		op_code == aalu_pkg::OP_LSR |=>
		flag_register[1] == $past(acc_out[0]) && !acc_out[15])
		else $error("logical shift wrong");
	chk_ptr_nostep: assert property (plain_op && // [RULE3]
		op_code == aalu_pkg::OP_MOVE_FROM_PTR
		|=> $stable(accumulator_index))
		else $error("pointer move stepped index");
	chk_jump_imm: assert property (op_valid && !src_is_imm && // [RULE22]
		op_code == aalu_pkg::OP_JUMP_E |=> op_illegal && !jump_taken)
		else $error("equals jump took register destination");
endmodule // aalu_core

// [test/aalu_decoder_model.sv]
// decoder-side model: issues alu operations and direct writes
`timescale 1ns/1ps
module aalu_decoder_model (
	input wire logic clk
);
	logic op_valid = 1'b0;
	aalu_pkg::aalu_op_type op_code = aalu_pkg::OP_NOP;
	logic [15:0] src_data = 16'h0000;
	logic [2:0] mods = 3'h0; // src acc, dst acc, imm dest
	logic [2:0] bit_sel = 3'h0;
	logic imm_bit = 1'b0;
	logic [3:0] wr = 4'h0; // acc, flag, step, index strobes
	logic [15:0] wdata = 16'h0000;
	logic [3:0] wsel = 4'h0;

	// one operation, taken at the second edge
	task automatic op(input logic [5:0] c, input logic [15:0] d = 16'h0000,
		input logic [2:0] m = 3'h0, input logic [2:0] b = 3'h0,
		input logic i = 1'b0);
		@(posedge clk);
		#1;
		op_code = aalu_pkg::aalu_op_type'(c);
		src_data = d;
		mods = m;
		bit_sel = b;
		imm_bit = i;
		op_valid = 1'b1;
		@(posedge clk);
		#1;
		op_valid = 1'b0;
	endtask

	// direct write: k 0 index, 1 step, 2 flags, 3 accumulator s
	task automatic put(input int k, input logic [15:0] d,
		input logic [3:0] s = 4'h0);
		@(posedge clk);
		#1;
		wdata = d;
		wsel = s;
		wr[k] = 1'b1;
		@(posedge clk);
		#1;
		wr = 4'h0;
	endtask
endmodule // aalu_decoder_model

// [test/tb_top.sv]
// self-checking bench of the accumulator alu
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [15:0] acc_out;
	logic [15:0] move_data;
	logic [3:0] idx;
	logic [7:0] stepc;
	logic [7:0] flags;
	logic jump_taken;
	logic op_illegal;
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [15:0] ares [15] = '{16'h7BDE, 16'h7BDF, 16'h0843, 16'h0842,
		16'hC210, 16'h4210, 16'h0842, 16'h1084, 16'h4210, 16'hC210,
		16'hE108, 16'hF842, 16'h4210, 16'h4812, 16'h2184};
	localparam logic [14:0] ACARRY = 15'h1268;
	logic [7:0] codes [10] = '{8'h01, 8'h41, 8'h02, 8'h42, 8'h03, 8'h43,
		8'h04, 8'h44, 8'h00, 8'h05};

	always #4 clk = ~clk;

	aalu_decoder_model pm (.clk(clk));

	aalu_core dut (.clk(clk), .reset(reset), .op_valid(pm.op_valid),
		.op_code(pm.op_code), .src_data(pm.src_data),
		.src_is_acc(pm.mods[2]), .dst_is_acc(pm.mods[1]),
		.src_is_imm(pm.mods[0]), .bit_sel(pm.bit_sel),
		.imm_bit(pm.imm_bit), .index_wr(pm.wr[0]),
		.index_wdata(pm.wdata[3:0]), .step_ctrl_wr(pm.wr[1]),
		.step_ctrl_wdata(pm.wdata[7:0]), .flag_wr(pm.wr[2]),
		.flag_wdata(pm.wdata[7:0]), .acc_wr(pm.wr[3]),
		.acc_wr_sel(pm.wsel), .acc_wr_data(pm.wdata),
		.acc_out(acc_out), .move_data(move_data),
		.accumulator_index(idx), .index_step_control(stepc),
		.flag_register(flags), .jump_taken(jump_taken),
		.op_illegal(op_illegal));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// expected index after one stepping operation
	function automatic logic [3:0] stepped(input logic [3:0] i,
		input logic [7:0] c);
		logic [3:0] m;
		logic [3:0] s;
		m = (c[2:0] == 3'h1) ? 4'h1 : (c[2:0] == 3'h2) ? 4'h3 :
			(c[2:0] == 3'h3) ? 4'h7 : (c[2:0] == 3'h4) ? 4'hF : 4'h0;
		s = c[6] ? i - 4'h1 : i + 4'h1;
		return (i & ~m) | (s & m);
	endfunction

	// reset state, then modulo-4 add walk from index 2
	task automatic t_walk;
		logic [3:0] ei [5] = '{4'h3, 4'h0, 4'h1, 4'h2, 4'h3};
		logic [15:0] ea [5] = '{16'h0, 16'h0, 16'h0, 16'h1, 16'h2};
		check(flags, 8'h80);
		check(stepc, 8'h00);
		pm.put(0, 16'h2);
		pm.put(1, 16'h02);
		for (int k = 0; k < 5; k++) begin
			pm.op(6'h01, 16'(k + 1));
			check(idx, ei[k]);
			check(acc_out, ea[k]);
		end
		$display("test walk done");
	endtask

	// step modes 1 to 4 up and down, plus mode codes 0 and 5 up, from index 9
	task automatic t_codes;
		for (int k = 0; k < 10; k++) begin
			pm.put(0, 16'h9);
			pm.put(1, 16'(codes[k]));
			check(stepc, codes[k]);
			pm.op(6'h09);
			check(idx, stepped(4'h9, codes[k]));
		end
		$display("test codes done");
	endtask

	// chained add, overflow and borrow
	task automatic t_arith;
		pm.put(1, 16'h01);
		pm.put(0, 16'h0);
		pm.put(3, 16'h5678, 4'h0);
		pm.put(3, 16'h1234, 4'h1);
		pm.op(6'h01, 16'hAAAA);
		check(flags[1], 1'b1);
		pm.op(6'h02, 16'h0AAA);
		check(acc_out, 16'h0122);
		pm.put(0, 16'h1);
		check(acc_out, 16'h1CDF);
		pm.put(1, 16'h00);
		pm.put(3, 16'h7FFF, 4'h1);
		pm.op(6'h01, 16'h0001);
		check(flags, 8'h44);
		pm.put(3, 16'h0000, 4'h1);
		pm.op(6'h03, 16'h0001);
		check(flags, 8'h42);
		pm.op(6'h04, 16'h0000);
		check(acc_out, 16'hFFFE);
		check(flags, 8'h40);
		$display("test arith done");
	endtask

	// compare, jumps and refused forms
	task automatic t_cmp;
		pm.put(1, 16'h04);
		pm.put(0, 16'h3);
		pm.put(3, 16'h1234, 4'h3);
		pm.op(6'h08, 16'h1234);
		check(flags[0], 1'b1);
		check({idx, acc_out}, {4'h3, 16'h1234});
		pm.op(6'h08, 16'h1235);
		check(flags[0], 1'b0);
		pm.op(6'h24, 16'h0010, 3'h1);
		check(jump_taken, 1'b1);
		pm.op(6'h23, 16'h0010, 3'h0);
		check({jump_taken, op_illegal}, 2'b01);
		pm.op(6'h01, 16'h0001, 3'h4);
		check(op_illegal, 1'b1);
		check({idx, acc_out}, {4'h3, 16'h1234});
		pm.op(6'h1A, 16'h0000, 3'h2);
		check({op_illegal, idx}, {1'b1, 4'h3});
		$display("test compare done");
	endtask

	// accumulator-only operations on 8421h with carry clear
	task automatic t_accops;
		pm.put(1, 16'h00);
		pm.put(0, 16'h0);
		for (int k = 0; k < 15; k++) begin
			pm.put(3, 16'h8421, 4'h0);
			pm.put(2, 16'h00);
			pm.op(6'h09 + 6'(k));
			check(acc_out, ares[k]);
			check(flags[1], ACARRY[k]);
		end
		$display("test acc ops done");
	endtask

	// carry bit operations with full stepping enabled
	task automatic t_bits;
		logic [5:0] bo [12] = '{6'h1B, 6'h1C, 6'h1D, 6'h1E, 6'h1F, 6'h20,
			6'h21, 6'h22, 6'h20, 6'h1B, 6'h21, 6'h1C};
		logic [2:0] bb [12] = '{3'h5, 3'h0, 3'h1, 3'h5, 3'h5, 3'h0, 3'h0,
			3'h0, 3'h0, 3'h7, 3'h0, 3'h7};
		logic bi [12] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1,
			1'h0, 1'h0, 1'h0, 1'h0};
		logic [11:0] ec = 12'hCAB;
		pm.put(1, 16'h04);
		pm.put(0, 16'h0);
		pm.put(3, 16'h0020, 4'h0);
		pm.put(2, 16'h00);
		for (int k = 0; k < 12; k++) begin
			pm.op(bo[k], 16'h0000, 3'h0, bb[k], bi[k]);
			check(flags[1], ec[k]);
			check(idx, 4'h0);
		end
		check(acc_out, 16'h00A1);
		pm.op(6'h1A);
		check({idx, move_data}, {4'h0, 16'h00A1});
		pm.op(6'h19);
		check({idx, move_data}, {4'h1, 16'h00A1});
		pm.put(2, 16'h01);
		pm.put(3, 16'h8000, 4'h5);
		pm.put(0, 16'h5);
		check(flags, 8'h41);
		$display("test bits done");
	endtask

	// cut a hang short
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			num_errors++;
			report_and_stop;
		end
	end

	initial begin
		repeat (6) @(posedge clk);
		#1;
		reset = 1'b0;
		t_walk;
		t_codes;
		t_arith;
		t_cmp;
		t_accops;
		t_bits;
		report_and_stop;
	end
endmodule // tb_top
